// ===== hdl/nwg_pkg.sv
package nwg_pkg;

  // command codes subject to the network write filter
  localparam int unsigned NWG_NUM_CODES = 24;
  localparam logic [NWG_NUM_CODES*16-1:0] NWG_CODES = {
    16'h0102, 16'h0103, 16'h0105, 16'h0202, 16'h0203, 16'h0307,
    16'h0308, 16'h0401, 16'h0402, 16'h0702, 16'h0C01, 16'h2101,
    16'h2103, 16'h2203, 16'h2204, 16'h2205, 16'h2207, 16'h2208,
    16'h220A, 16'h220B, 16'h220C, 16'h2215, 16'h2301, 16'h2302
  };

  // register map (word offsets of the plain register port)
  localparam logic [7:0] NWG_REG_CTRL   = 8'h00;
  localparam logic [7:0] NWG_REG_STATUS = 8'h01;
  localparam logic [7:0] NWG_REG_LOCAL  = 8'h02;
  localparam logic [7:0] NWG_REG_EXCL0  = 8'h20;

  // control word fields
  localparam int unsigned NWG_CTRL_PROT_BIT = 15;
  localparam int unsigned NWG_CTRL_HOP7_BIT = 14;
  localparam logic [15:0] NWG_CTRL_RESET    = 16'h0000;

  // hop counter start values and reach
  localparam logic [7:0] NWG_HOP_START_DEF  = 8'h02;
  localparam logic [7:0] NWG_HOP_START_DEEP = 8'h07;
  localparam logic [3:0] NWG_MAX_LVL_CTRL   = 4'h8;
  localparam logic [3:0] NWG_MAX_LVL_OTHER  = 4'h3;
  localparam logic [3:0] NWG_MAX_LVL_SLOW   = 4'h3;
  localparam logic [7:0] NWG_NODE_ANY       = 8'hFF;

  // routing error codes
  localparam logic [15:0] NWG_ERR_NONE     = 16'h0000;
  localparam logic [15:0] NWG_ERR_PROTECT  = 16'h2101;
  localparam logic [15:0] NWG_ERR_NO_DEST  = 16'h0501;
  localparam logic [15:0] NWG_ERR_HOP_ZERO = 16'h0502;
  localparam logic [15:0] NWG_ERR_LEVELS   = 16'h0503;
  localparam logic [15:0] NWG_ERR_SLOW_NET = 16'h0504;

  typedef enum logic [1:0] {
    NWG_SRC_NET,
    NWG_SRC_SERIAL,
    NWG_SRC_INTERNAL
  } nwg_src_t;

  typedef struct packed {
    logic [15:0] code;
    nwg_src_t    src;
    logic [6:0]  src_net;
    logic [7:0]  src_node;
    logic [7:0]  hop;
    logic        forward;
    logic        dest_ctrl;
    logic        next_slow;
    logic        next_serial_gw;
    logic [3:0]  levels;
    logic [3:0]  slow_levels;
  } nwg_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        accept;
    logic        forward;
    logic [7:0]  hop;
    logic [15:0] err;
  } nwg_res_t;

  typedef struct packed {
    logic [14:0] entry;
    logic        used;
  } nwg_excl_t;

endpackage

// ===== hdl/nwg_guard.sv
`timescale 1ns/1ns
`default_nettype none
module nwg_guard
  import nwg_pkg::*;
#(
  parameter int unsigned NUM_EXCL = 32
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        cmd_valid,
  input  wire nwg_cmd_t    cmd,
  output nwg_res_t         res,
  output logic [15:0]      start_hop,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);

  if (NUM_EXCL < 1 || NUM_EXCL > 32) begin : g_excl_range
    $error("NUM_EXCL must be 1 to 32");
  end

  typedef struct packed {
    logic [15:0]              ctrl;
    logic [15:0]              local_addr;
    logic [NUM_EXCL*16-1:0]   excl;
    nwg_res_t                 res;
    logic [15:0]              rdata;
    logic [15:0]              rej_cnt;
    logic [15:0]              last_err;
    logic [15:0]              start_hop;
  } nwg_state_t;

  nwg_state_t st;
  nwg_state_t next_st;

  logic       prot_on;
  logic [5:0] excl_num;
  logic       listed;
  logic       excl_hit;
  logic       is_local;
  logic       filtered;
  logic       reject;
  logic [3:0] reach;
  logic [4:0] lvl_after;
  logic [15:0] route_err;
  logic [7:0]  hop_after;
  logic [15:0] entry;

  assign prot_on  = st.ctrl[NWG_CTRL_PROT_BIT];
  assign excl_num = st.ctrl[5:0];

  always_comb begin
    listed = 1'b0;
    for (int i = 0; i < NWG_NUM_CODES; i++) begin
      if (cmd.code == NWG_CODES[i*16 +: 16]) begin
        listed = 1'b1;
      end
    end
  end

  always_comb begin
    excl_hit = 1'b0;
    entry    = 16'h0000;
    for (int i = 0; i < NUM_EXCL; i++) begin
      entry = st.excl[i*16 +: 16];
      if (6'(i) < excl_num && entry[14:8] == cmd.src_net &&
          (entry[7:0] == NWG_NODE_ANY || entry[7:0] == cmd.src_node)) begin
        excl_hit = 1'b1;
      end
    end
  end

  // zero entries leaves only the local node writable
  assign is_local = (cmd.src_net == st.local_addr[14:8]) &&
                    (cmd.src_node == st.local_addr[7:0]);

  // serial and internal sources bypass the filter entirely
  assign filtered = prot_on && listed &&
                    (cmd.src == NWG_SRC_NET);
  assign reject   = filtered && !excl_hit &&
                    !(excl_num == 6'd0 && is_local);

  // a serial gateway is not a level, so it never spends budget
  assign lvl_after = {1'b0, cmd.levels} +
                     (cmd.next_serial_gw ? 5'h00 : 5'h01);
  assign reach     = cmd.dest_ctrl ? NWG_MAX_LVL_CTRL
                                   : NWG_MAX_LVL_OTHER;
  assign hop_after = cmd.next_serial_gw ? cmd.hop
                                        : cmd.hop - 8'h01;

  always_comb begin
    route_err = NWG_ERR_NONE;
    if (cmd.forward) begin
      if (!cmd.next_serial_gw && cmd.hop == 8'h00) begin
        route_err = NWG_ERR_HOP_ZERO;
      end else if (lvl_after > {1'b0, reach}) begin
        route_err = NWG_ERR_LEVELS;
      end else if (cmd.next_slow && !cmd.next_serial_gw &&
                   cmd.slow_levels >= NWG_MAX_LVL_SLOW) begin
        route_err = NWG_ERR_SLOW_NET;
      end else if (cmd.next_slow && lvl_after > {1'b0, NWG_MAX_LVL_SLOW}) begin
        route_err = NWG_ERR_SLOW_NET;
      end
    end
  end

  always_comb begin
    next_st           = st;
    next_st.res.valid = cmd_valid;
    next_st.res.accept  = 1'b0;
    next_st.res.forward = 1'b0;
    next_st.res.hop     = cmd.hop;
    next_st.res.err     = NWG_ERR_NONE;
    if (cmd_valid) begin
      if (reject) begin
        next_st.res.err = NWG_ERR_PROTECT;
      end else if (route_err != NWG_ERR_NONE) begin
        next_st.res.err = route_err;
      end else begin
        next_st.res.accept  = 1'b1;
        next_st.res.forward = cmd.forward;
        next_st.res.hop     = cmd.forward ? hop_after : cmd.hop;
      end
      if (next_st.res.err != NWG_ERR_NONE) begin
        next_st.last_err = next_st.res.err;
        if (st.rej_cnt != 16'hFFFF) begin
          next_st.rej_cnt = st.rej_cnt + 16'h0001;
        end
      end
    end
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == NWG_REG_CTRL) begin
        next_st.rdata = st.ctrl;
      end else if (reg_addr == NWG_REG_STATUS) begin
        next_st.rdata = st.rej_cnt;
      end else if (reg_addr == NWG_REG_LOCAL) begin
        next_st.rdata = st.local_addr;
      end else if (reg_addr == NWG_REG_LOCAL + 8'h01) begin
        next_st.rdata = st.last_err;
      end else if (reg_addr >= NWG_REG_EXCL0 &&
                   reg_addr < NWG_REG_EXCL0 + 8'(NUM_EXCL)) begin
        next_st.rdata = st.excl[(reg_addr - NWG_REG_EXCL0) * 16 +: 16];
      end
    end
    if (reg_wr) begin
      if (reg_addr == NWG_REG_CTRL) begin
        // entry count clamps to what the table holds
        next_st.ctrl = reg_wdata;
        if (reg_wdata[5:0] > 6'(NUM_EXCL)) begin
          next_st.ctrl[5:0] = 6'(NUM_EXCL);
        end
      end else if (reg_addr == NWG_REG_LOCAL) begin
        next_st.local_addr = {1'b0, reg_wdata[14:0]};
      end else if (reg_addr >= NWG_REG_EXCL0 &&
                   reg_addr < NWG_REG_EXCL0 + 8'(NUM_EXCL)) begin
        next_st.excl[(reg_addr - NWG_REG_EXCL0) * 16 +: 16] =
          {1'b0, reg_wdata[14:0]};
      end
    end
    // registered with ctrl so the pin leaves a flip-flop
    next_st.start_hop = {8'h00, NWG_HOP_START_DEF};
    if (next_st.ctrl[NWG_CTRL_HOP7_BIT]) begin
      next_st.start_hop = {8'h00, NWG_HOP_START_DEEP};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st           <= '0;
      st.ctrl      <= NWG_CTRL_RESET;
      st.start_hop <= {8'h00, NWG_HOP_START_DEF};
    end else begin
      st <= next_st;
    end
  end

  assign res       = st.res;
  assign reg_rdata = st.rdata;
  // start value for frames this node originates
  assign start_hop = st.start_hop;

  default clocking nwg_cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence net_write_s;
    cmd_valid && prot_on && listed && cmd.src == NWG_SRC_NET;
  endsequence

  sequence unexempt_s;
    net_write_s ##0 (!excl_hit && excl_num != 6'd0);
  endsequence

  sequence refused_s;
    !res.accept && res.err == NWG_ERR_PROTECT;
  endsequence

  sequence crossing_s;
    cmd_valid && cmd.forward && !cmd.next_serial_gw;
  endsequence

  // a listed network write with protection on and no exemption never passes
  protect_block_a: assert property (
    unexempt_s |=> refused_s)
    else $error("protected write accepted");

  excl_exempt_a: assert property (
    net_write_s ##0 excl_hit |=> res.err != NWG_ERR_PROTECT)
    else $error("excluded source refused");

  local_exempt_a: assert property (
    net_write_s ##0 (excl_num == 6'd0 && is_local) |=>
    res.err != NWG_ERR_PROTECT)
    else $error("local node refused");

  zero_list_a: assert property (
    net_write_s ##0 (excl_num == 6'd0 && !is_local) |=> refused_s)
    else $error("foreign node passed with empty list");

  unlisted_pass_a: assert property (
    cmd_valid && !listed |=> res.err != NWG_ERR_PROTECT)
    else $error("unlisted code refused");

  serial_pass_a: assert property (
    cmd_valid && cmd.src != NWG_SRC_NET && !cmd.forward |=> res.accept)
    else $error("serial or internal command refused");

  internal_pass_a: assert property (
    cmd_valid && cmd.src == NWG_SRC_INTERNAL |=>
    res.err != NWG_ERR_PROTECT)
    else $error("internal write refused");

  prot_off_a: assert property (
    cmd_valid && !prot_on && !cmd.forward |=> res.accept)
    else $error("command refused with protection off");

  prot_off_code_a: assert property (
    cmd_valid && !prot_on |=> res.err != NWG_ERR_PROTECT)
    else $error("protect error with protection off");

  hop_dec_a: assert property (
    crossing_s |=> !res.accept || res.hop == $past(cmd.hop) - 8'h01)
    else $error("hop counter not decremented");

  hop_kept_a: assert property (
    cmd_valid && !cmd.forward |=> res.hop == $past(cmd.hop))
    else $error("hop counter changed without crossing");

  hop_zero_a: assert property (
    crossing_s ##0 (!reject && cmd.hop == 8'h00) |=>
    !res.forward && res.err == NWG_ERR_HOP_ZERO)
    else $error("zero hop frame forwarded");

  gw_hop_a: assert property (
    cmd_valid && cmd.forward && cmd.next_serial_gw |=>
    !res.accept || res.hop == $past(cmd.hop))
    else $error("serial gateway spent hop budget");

  gw_zero_a: assert property (
    cmd_valid && cmd.forward && cmd.next_serial_gw && cmd.hop == 8'h00 |=>
    res.err != NWG_ERR_HOP_ZERO)
    else $error("serial gateway hit hop limit");

  reach_a: assert property (
    crossing_s ##0 (!cmd.dest_ctrl && cmd.levels >= 4'h3) |=> !res.forward)
    else $error("forwarded beyond three levels");

  ctrl_reach_a: assert property (
    crossing_s ##0 (cmd.levels >= 4'h8) |=> !res.forward)
    else $error("forwarded beyond eight levels");

  level_code_a: assert property (
    crossing_s ##0 (!reject && cmd.hop != 8'h00 && cmd.levels >= 4'h8) |=>
    res.err == NWG_ERR_LEVELS)
    else $error("level limit not reported");

  lvl_ok_a: assert property (
    crossing_s ##0 (!reject && cmd.dest_ctrl && cmd.hop != 8'h00 &&
    cmd.levels < 4'h3 && !cmd.next_slow) |=> res.forward)
    else $error("legal route to controller refused");

  slow_reach_a: assert property (
    crossing_s ##0 (cmd.next_slow &&
    (cmd.levels >= 4'h3 || cmd.slow_levels >= 4'h3)) |=> !res.forward)
    else $error("forwarded beyond three slow networks");

  err_range_a: assert property (
    res.valid && !res.accept && res.err != NWG_ERR_PROTECT |->
    res.err >= NWG_ERR_NO_DEST && res.err <= NWG_ERR_SLOW_NET)
    else $error("routing error code out of range");

  last_err_a: assert property (
    cmd_valid && !reject && route_err != NWG_ERR_NONE |=>
    st.last_err == $past(route_err))
    else $error("routing error not recorded");

  reject_no_exec_a: assert property (
    res.valid && res.err != NWG_ERR_NONE |-> !res.accept && !res.forward)
    else $error("rejected command executed");

  fwd_accept_a: assert property (
    res.forward |-> res.valid && res.accept)
    else $error("forward without accepted command");

  one_answer_a: assert property (
    res.valid == $past(cmd_valid))
    else $error("answer not one cycle after command");

  idle_result_a: assert property (
    !$past(cmd_valid) |->
    !res.accept && !res.forward && res.err == NWG_ERR_NONE)
    else $error("result flags without command");

  reject_count_a: assert property (
    cmd_valid && reject && st.rej_cnt != 16'hFFFF |=>
    st.rej_cnt == $past(st.rej_cnt) + 16'h0001)
    else $error("rejected command not counted");

  excl_clamp_a: assert property (
    excl_num <= 6'(NUM_EXCL))
    else $error("exclusion count above table size");

  read_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");

  start_hop_a: assert property (
    start_hop == 16'h0002 || start_hop == 16'h0007)
    else $error("bad start hop value");

endmodule
`default_nettype wire

// ===== sim/nwg_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module nwg_host_model
  import nwg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire nwg_res_t    res,
  input  wire logic [15:0] start_hop,
  output var logic         cmd_valid,
  output var nwg_cmd_t     cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // one frame per call; lines inverted after it so no stale value lingers
  task automatic send(input nwg_cmd_t c, input logic orig,
                      output logic [17:0] key, output logic [7:0] hop);
    @(posedge ref_clk);
    if (orig) begin
      c.hop = start_hop[7:0];
    end
    cmd_valid <= 1'b1;
    cmd       <= c;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd       <= nwg_cmd_t'(~c);
    #1;
    // hop kept out of the frame match, the route rewrites it
    key = {res.valid, res.accept, res.err};
    hop = res.hop;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import nwg_pkg::*;
;
  localparam logic [17:0] OK   = {2'b11, NWG_ERR_NONE};
  localparam logic [17:0] REJ  = {2'b10, NWG_ERR_PROTECT};
  localparam logic [17:0] HOPZ = {2'b10, NWG_ERR_HOP_ZERO};
  localparam logic [17:0] LVL  = {2'b10, NWG_ERR_LEVELS};
  localparam logic [17:0] SLOW = {2'b10, NWG_ERR_SLOW_NET};

  logic        ref_clk   = 1'b0;
  logic        arst_n    = 1'b0;
  logic        cmd_valid;
  nwg_cmd_t    cmd;
  nwg_res_t    res;
  logic [15:0] start_hop;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  logic [17:0] key;
  logic [7:0]  hop;
  logic [15:0] k;
  nwg_cmd_t    c;

  always #2 ref_clk = ~ref_clk;

  nwg_guard DUT (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .res(res), .start_hop(start_hop), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  nwg_host_model host (.ref_clk(ref_clk), .res(res), .start_hop(start_hop),
    .cmd_valid(cmd_valid), .cmd(cmd));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    cmp({2'b00, reg_rdata}, {2'b00, e});
  endtask

  task automatic go(input logic [15:0] code, input nwg_src_t s,
                    input logic [6:0] net, input logic [7:0] node,
                    input logic [17:0] e);
    c          = '0;
    c.code     = code;
    c.src      = s;
    c.src_net  = net;
    c.src_node = node;
    host.send(c, 1'b0, key, hop);
    cmp(key, e);
  endtask

  task automatic fw(input logic o, input logic [17:0] e,
                    input logic [7:0] h);
    host.send(c, o, key, hop);
    cmp(key, e);
    cmp({17'h0_0000, res.forward}, {17'h0_0000, e[16] & c.forward});
    if (e[16]) cmp({10'h000, hop}, {10'h000, h});
  endtask

  // budget well above the roughly 130 cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(NWG_REG_CTRL, 16'h0000);
    go(NWG_CODES[15:0], NWG_SRC_NET, 7'h01, 8'h05, OK);
    wr(NWG_REG_LOCAL, 16'h0109);
    wr(NWG_REG_CTRL, 16'h8000);
    for (int i = 0; i < NWG_NUM_CODES; i++) begin
      k = NWG_CODES[i*16 +: 16];
      go(k, NWG_SRC_NET, 7'h01, 8'h05, REJ);
    end
    go(16'h0101, NWG_SRC_NET, 7'h01, 8'h05, OK);
    go(16'h0102, NWG_SRC_SERIAL, 7'h01, 8'h05, OK);
    go(16'h0102, NWG_SRC_INTERNAL, 7'h01, 8'h05, OK);
    go(16'h2203, NWG_SRC_NET, 7'h01, 8'h09, OK);
    rd(NWG_REG_STATUS, 16'h0018);
    wr(NWG_REG_STATUS, 16'h0000);
    rd(NWG_REG_STATUS, 16'h0018);
    $display("test protect done");
    wr(NWG_REG_EXCL0, 16'h8105);
    wr(NWG_REG_EXCL0 + 8'h01, 16'h02FF);
    wr(NWG_REG_CTRL, 16'h8002);
    rd(NWG_REG_EXCL0, 16'h0105);
    go(16'h0401, NWG_SRC_NET, 7'h01, 8'h05, OK);
    go(16'h0401, NWG_SRC_NET, 7'h01, 8'h06, REJ);
    go(16'h0401, NWG_SRC_NET, 7'h02, 8'h33, OK);
    go(16'h0401, NWG_SRC_NET, 7'h01, 8'h09, REJ);
    rd(8'h10, 16'h0000);
    $display("test exclude done");
    wr(NWG_REG_CTRL, 16'h0000);
    c           = '0;
    c.code      = 16'h0101;
    c.src       = NWG_SRC_NET;
    c.forward   = 1'b1;
    c.dest_ctrl = 1'b1;
    fw(1'b1, OK, 8'h01);
    wr(NWG_REG_CTRL, 16'h4000);
    #1;
    cmp({2'b00, start_hop}, 18'h0_0007);
    fw(1'b1, OK, 8'h06);
    c.hop = 8'h00;
    fw(1'b0, HOPZ, 8'h00);
    c.hop    = 8'h05;
    c.levels = 4'h3;
    fw(1'b0, OK, 8'h04);
    c.levels = 4'h9;
    fw(1'b0, LVL, 8'h00);
    c.dest_ctrl = 1'b0;
    c.levels    = 4'h4;
    fw(1'b0, LVL, 8'h00);
    c.levels      = 4'h1;
    c.next_slow   = 1'b1;
    c.slow_levels = 4'h5;
    fw(1'b0, SLOW, 8'h00);
    c.levels      = 4'h3;
    c.slow_levels = 4'h0;
    c.dest_ctrl   = 1'b1;
    fw(1'b0, SLOW, 8'h00);
    rd(8'h03, NWG_ERR_SLOW_NET);
    c.next_slow      = 1'b0;
    c.next_serial_gw = 1'b1;
    c.hop            = 8'h03;
    fw(1'b0, OK, 8'h03);
    $display("test route done");
    summarize();
  end
endmodule
`default_nettype wire
